// *** rcd_ref_clock.sv ***
`timescale 1ns/1ps
`include "rcd_defines.svh"

module rcd_ref_clock
    import rcd_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input wire logic clk,                    // system clock, 40 MHz
    input wire logic rst,                    // synchronous reset, active high
    input wire logic psel,                   // apb select
    input wire logic penable,                // apb access phase
    input wire logic pwrite,                 // apb direction, high for write
    input wire logic [ADDR_W-1:0] paddr,     // apb byte address
    input wire logic [31:0] pwdata,          // apb write data
    output logic [31:0] prdata,              // apb read data
    output logic pready,                     // apb ready
    output logic pslverr,                    // apb error on unmapped address
    input wire logic sleep,                  // device sleep, same clock domain
    input wire logic crystalModeSel,         // any crystal oscillator mode, config pin
    input wire logic foscQuarterOutputEnable, // quarter-rate output option, config pin
    output logic refClockOutPin,             // shared pin data
    output logic refClockPinOe,              // shared pin output enable
    output logic refClockSlewLimit,          // pad slew limiting on
    output logic modulatorClock              // internal clock to the modulator
);
    if (ADDR_W < 3) begin : g_bad_addr_w
        $error("rcd_ref_clock: ADDR_W too small for the map");
    end

    // control register and its fields
    // the fields are plain slices; nothing is decoded apart
    logic [7:0] refClockControlReg;          // software settings
    logic [7:0] next_ctrl;
    logic refClockEnable;
    logic refClockPinDriveEnable;
    rcd_div_t refClockDividerSelect;
    rcd_duty_t refClockDutySelect;
    logic refClockSlewBit;

    // apb answer registers
    logic next_pready;
    logic next_pslverr;
    logic [31:0] next_prdata;
    logic [31:0] statusWord;                  // live status view
    logic addrCtrl;
    logic addrStat;
    logic setupPhase;
    logic writeTaken;

    // synchronised configuration levels
    // bit 0 is the crystal mode, bit 1 the quarter-rate option
    logic [1:0] cfgSync;
    logic crystalMode;
    logic quarterEnable;

    // quarter-rate oscillator clock
    // a two-bit counter divides the system clock by four
    logic [1:0] quarterCnt;
    logic [1:0] next_quarterCnt;
    logic foscQuarterOutput;
    logic next_quarter;

    // pin ownership and pad controls
    // the owner decides what the shared pin carries and if it is driven
    rcd_pin_owner_e pinOwner;
    rcd_pin_owner_e next_pinOwner;
    logic next_oe;
    logic next_slew;
    logic next_modClk;
    logic pinDataReg;
    logic next_pinData;

    // settings go down and the clock and phase come back in one bundle
    rcd_ctrl_if ctlBus ();

    // configuration options come from outside this clock's domain
    // a change counts only once two later stages agree, so a slow
    // option edge cannot flip pin ownership back and forth
    rcd_sync3 #(
        .WIDTH(2)
    ) u_cfg_sync (
        .clk(clk),
        .rst(rst),
        .din({foscQuarterOutputEnable, crystalModeSel}),
        .dout(cfgSync)
    );

    assign crystalMode = cfgSync[0];
    assign quarterEnable = cfgSync[1];

    // field views of the control register
    // bits above 7 are not stored and read back as zero
    assign refClockDividerSelect = refClockControlReg[`RCD_DIV_MSB:`RCD_DIV_LSB];
    assign refClockDutySelect = refClockControlReg[`RCD_DUTY_MSB:`RCD_DUTY_LSB];
    assign refClockSlewBit = refClockControlReg[`RCD_SLEW_BIT];
    assign refClockPinDriveEnable = refClockControlReg[`RCD_OE_BIT];
    assign refClockEnable = refClockControlReg[`RCD_EN_BIT];

    // settings to the generator; enable is honoured whatever owns the pin
    assign ctlBus.enable = refClockEnable;
    assign ctlBus.divSel = refClockDividerSelect;
    assign ctlBus.dutySel = refClockDutySelect;
    assign ctlBus.sleep = sleep;

    // the divider runs from the system clock alone, whatever owns the pin
    rcd_divider u_divider (
        .clk(clk),
        .rst(rst),
        .ctl(ctlBus)
    );

    // address decode and status assembly
    // the full address is compared, so aliases answer with an error
    // status is a live view: nothing in it is latched or cleared by a read
    always_comb begin
        addrCtrl = (paddr == ADDR_W'(`RCD_ADDR_CTRL));
        addrStat = (paddr == ADDR_W'(`RCD_ADDR_STAT));
        setupPhase = psel & ~penable;
        writeTaken = psel & penable & pready & pwrite & addrCtrl;
        statusWord = 32'h0000_0000;
        statusWord[`RCD_STAT_OWNER_MSB:`RCD_STAT_OWNER_LSB] = pinOwner;
        statusWord[`RCD_STAT_XTAL_BIT] = crystalMode;
        statusWord[`RCD_STAT_QUARTER_BIT] = quarterEnable;
        statusWord[`RCD_STAT_LEVEL_BIT] = ctlBus.level;
        statusWord[`RCD_STAT_SLEEP_BIT] = sleep;
    end

    // apb answer: ready is raised for the first access cycle, so no wait states
    // the answer is built during setup and registered, so it leaves flops;
    // prdata then holds until the next setup
    always_comb begin
        next_pready = 1'b0;
        next_pslverr = 1'b0;
        next_prdata = prdata;
        if (setupPhase) begin
            next_pready = 1'b1;
            next_pslverr = ~(addrCtrl | addrStat);
            if (!pwrite && addrCtrl) begin
                next_prdata = {24'h00_0000, refClockControlReg};
            end else if (!pwrite && addrStat) begin
                next_prdata = statusWord;
            end else begin
                // unmapped reads and all writes return zero
                next_prdata = 32'h0000_0000;
            end
        end
    end

    // answer registers; pready falls again after one cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= next_pready;
            pslverr <= next_pslverr;
            prdata <= next_prdata;
        end
    end

    // control register: writes land at the access edge; reset restores
    // defaults, leaving the generator off until firmware sets it up
    // writes to the status word or an unmapped address change nothing
    always_comb begin
        next_ctrl = refClockControlReg;
        if (writeTaken) begin
            next_ctrl = pwdata[7:0];
        end
    end

    // only rst restores the settings; sleep leaves them in place
    always_ff @(posedge clk) begin
        if (rst) begin
            refClockControlReg <= `RCD_CTRL_RESET;
        end else begin
            refClockControlReg <= next_ctrl;
        end
    end

    // quarter-rate oscillator clock, 50% duty; it also freezes in sleep
    // because the oscillator clock itself stops there
    // it runs whether or not the option is selected, so the quarter
    // clock is already running when ownership passes to it
    always_comb begin
        next_quarterCnt = quarterCnt;
        next_quarter = foscQuarterOutput;
        if (!sleep) begin
            next_quarterCnt = 2'((quarterCnt + 2'h1) % `RCD_QUARTER_DIV);
            next_quarter = (next_quarterCnt < 2'(`RCD_QUARTER_DIV / 2));
        end
    end

    // quarter counter and its registered output
    always_ff @(posedge clk) begin
        if (rst) begin
            quarterCnt <= 2'h0;
            foscQuarterOutput <= 1'b0;
        end else begin
            quarterCnt <= next_quarterCnt;
            foscQuarterOutput <= next_quarter;
        end
    end

    // pin ownership: crystal mode first, then the quarter output, then us
    // an oscillator on the pin cannot be overdriven, and the quarter
    // option is a configuration choice that software cannot override
    // ownership is frozen in sleep, so the pin select cannot move while held
    always_comb begin
        if (sleep) begin
            next_pinOwner = pinOwner;
        end else if (crystalMode) begin
            next_pinOwner = RCD_PIN_OSC;
        end else if (quarterEnable) begin
            next_pinOwner = RCD_PIN_QUARTER;
        end else if (refClockPinDriveEnable) begin
            next_pinOwner = RCD_PIN_REF;
        end else begin
            next_pinOwner = RCD_PIN_IDLE;
        end
    end

    // pad controls registered; sleep holds them where they stand
    // enable and owner are registered together, so the pin data select
    // and the enable never disagree for a cycle
    always_comb begin
        next_oe = refClockPinOe;
        next_slew = refClockSlewLimit;
        next_pinData = pinDataReg;
        if (!sleep) begin
            unique case (next_pinOwner)
                RCD_PIN_OSC: begin
                    next_oe = 1'b0;
                    next_pinData = 1'b0;
                end
                RCD_PIN_QUARTER: begin
                    next_oe = 1'b1;
                    next_pinData = next_quarter;
                end
                RCD_PIN_REF: begin
                    next_oe = 1'b1;
                    next_pinData = 1'b0;
                end
                RCD_PIN_IDLE: begin
                    next_oe = 1'b0;
                    next_pinData = 1'b0;
                end
            endcase
            next_slew = refClockSlewBit;
        end
    end

    // the pad resets undriven with slew limiting on, safe for a shared pin
    always_ff @(posedge clk) begin
        if (rst) begin
            pinOwner <= RCD_PIN_IDLE;
            refClockPinOe <= 1'b0;
            refClockSlewLimit <= 1'b1;
            pinDataReg <= 1'b0;
        end else begin
            pinOwner <= next_pinOwner;
            refClockPinOe <= next_oe;
            refClockSlewLimit <= next_slew;
            pinDataReg <= next_pinData;
        end
    end

    // pin data: the reference path passes the generated clock itself, since
    // the base rate cannot be rebuilt by a register on the same clock
    // limitation: the pad must accept a gated copy of the system clock
    always_comb begin
        if (pinOwner == RCD_PIN_REF) begin
            refClockOutPin = ctlBus.refClk;
        end else begin
            refClockOutPin = pinDataReg;
        end
    end

    // the modulator always sees the generated clock, pin or no pin
    // it taps the clock ahead of the pin select, so a crystal or quarter
    // owner never starves the modulator
    always_comb begin
        next_modClk = ctlBus.refClk;
        modulatorClock = next_modClk;
    end
endmodule

// *** rcd_defines.svh ***
`ifndef RCD_DEFINES_SVH
`define RCD_DEFINES_SVH

// register byte addresses
`define RCD_ADDR_CTRL 12'h000
`define RCD_ADDR_STAT 12'h004

// control register field positions
`define RCD_DIV_LSB 0
`define RCD_DIV_MSB 2
`define RCD_DUTY_LSB 3
`define RCD_DUTY_MSB 4
`define RCD_SLEW_BIT 5
`define RCD_OE_BIT 6
`define RCD_EN_BIT 7

// control register reset value: off, not driven, slew limited, 50% duty, base rate
`define RCD_CTRL_RESET 8'h30

// status register field positions
`define RCD_STAT_OWNER_LSB 0
`define RCD_STAT_OWNER_MSB 1
`define RCD_STAT_XTAL_BIT 2
`define RCD_STAT_QUARTER_BIT 3
`define RCD_STAT_LEVEL_BIT 4
`define RCD_STAT_SLEEP_BIT 5

// oscillator clock divided by this for the quarter-rate output
`define RCD_QUARTER_DIV 4

`endif

// *** rcd_pkg.sv ***
package rcd_pkg;

    // who owns the shared output pin
    typedef enum logic [1:0] {
        RCD_PIN_IDLE,
        RCD_PIN_OSC,
        RCD_PIN_QUARTER,
        RCD_PIN_REF
    } rcd_pin_owner_e;

    typedef logic [2:0] rcd_div_t;
    typedef logic [1:0] rcd_duty_t;

endpackage

// *** rcd_ctrl_if.sv ***
`timescale 1ns/1ps
interface rcd_ctrl_if;
    import rcd_pkg::*;

    logic enable;      // generator runs
    rcd_div_t divSel;  // power-of-two divider select
    rcd_duty_t dutySel; // high-time select
    logic sleep;       // freeze request
    logic refClk;      // generated reference clock
    logic level;       // registered phase level, for status

    modport ctl (output enable, output divSel, output dutySel, output sleep,
        input refClk, input level);
    modport gen (input enable, input divSel, input dutySel, input sleep,
        output refClk, output level);
endinterface

// *** rcd_sync3.sv ***
`timescale 1ns/1ps
module rcd_sync3 #(
    parameter int WIDTH = 2
) (
    input wire logic clk,              // system clock
    input wire logic rst,              // synchronous reset
    input wire logic [WIDTH-1:0] din,  // asynchronous levels
    output logic [WIDTH-1:0] dout      // filtered levels
);
    if (WIDTH < 1) begin : g_bad_width
        $error("rcd_sync3: WIDTH must be at least 1");
    end

    // one three-stage chain per bit; the first stage feeds only the second
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        logic s1, s2, s3;
        logic next_out;
        always_comb begin
            // accept a change only when stages two and three agree
            next_out = (s2 == s3) ? s3 : dout[i];
        end
        always_ff @(posedge clk) begin
            if (rst) begin
                s1 <= 1'b0;
                s2 <= 1'b0;
                s3 <= 1'b0;
                dout[i] <= 1'b0;
            end else begin
                s1 <= din[i];
                s2 <= s1;
                s3 <= s2;
                dout[i] <= next_out;
            end
        end
    end
endmodule

// *** rcd_divider.sv ***
`timescale 1ns/1ps
module rcd_divider
    import rcd_pkg::*;
(
    input wire logic clk,  // system clock, the only source
    input wire logic rst,  // synchronous reset
    rcd_ctrl_if.gen ctl    // settings in, clock out
);
    logic [6:0] cnt;        // position within one output period
    logic [6:0] next_cnt;
    logic level;            // registered high phase
    logic next_level;
    logic held;             // level frozen for sleep
    logic next_held;
    logic [6:0] lastCnt;    // period minus one
    logic [7:0] highCnt;    // cycles high per period
    logic running;

    always_comb begin
        // period is two to the power of the select, base clock up to /128
        lastCnt = 7'(({1'b0, 7'h7f}) >> (3'h7 - ctl.divSel));
        // high cycles: duty quarter times the period
        // ten bits so that 75% of /128 (384) survives before the shift
        highCnt = 8'(({8'h00, ctl.dutySel} * (10'h001 << ctl.divSel)) >> 2);
        running = ctl.enable & ~ctl.sleep;
        next_cnt = cnt;
        next_held = held;
        if (!ctl.enable) begin
            next_cnt = 7'h00;
        end else if (running) begin
            next_cnt = (cnt >= lastCnt) ? 7'h00 : 7'(cnt + 7'h01);
            next_held = level;
        end
        // at /2 the 50% phase is the first cycle; wider ratios compare
        if (ctl.divSel == 3'h1) begin
            next_level = (next_cnt == 7'h00);
        end else if (ctl.divSel == 3'h0) begin
            next_level = (ctl.dutySel != 2'h0);
        end else begin
            next_level = ({1'b0, next_cnt} < highCnt);
        end
        if (!ctl.enable) begin
            next_level = 1'b0; // a re-enable starts from a low phase
        end else if (ctl.sleep) begin
            next_level = level;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cnt <= 7'h00;
            level <= 1'b0;
            held <= 1'b0;
        end else begin
            cnt <= next_cnt;
            level <= next_level;
            held <= next_held;
        end
    end

    // base rate and /2 quarter duties use the source clock edges, so their
    // accuracy follows the source duty; all other settings are pure registers
    always_comb begin
        if (!ctl.enable) begin
            ctl.refClk = 1'b0;
        end else if (ctl.sleep) begin
            ctl.refClk = held;
        end else if (ctl.divSel == 3'h0) begin
            ctl.refClk = clk & (ctl.dutySel != 2'h0);
        end else if (ctl.divSel == 3'h1 && ctl.dutySel == 2'h1) begin
            ctl.refClk = level & clk;
        end else if (ctl.divSel == 3'h1 && ctl.dutySel == 2'h3) begin
            ctl.refClk = level | clk;
        end else if (ctl.divSel == 3'h1 && ctl.dutySel == 2'h0) begin
            ctl.refClk = 1'b0;
        end else begin
            ctl.refClk = level;
        end
    end

    assign ctl.level = level;
endmodule

// *** rcd_ref_clock_asserts.sv ***
`timescale 1ns/1ps
module rcd_ref_clock_asserts #(
    parameter int ADDR_W = 12
) (
    input wire logic clk, // clock
    input wire logic rst, // reset
    input wire logic psel, // select
    input wire logic penable, // access
    input wire logic pwrite, // write
    input wire logic [ADDR_W-1:0] paddr, // address
    input wire logic [31:0] pwdata, // write data
    input wire logic [31:0] prdata, // read data
    input wire logic pready, // ready
    input wire logic pslverr, // error
    input wire logic sleep, // sleep
    input wire logic crystalModeSel, // crystal mode
    input wire logic foscQuarterOutputEnable, // quarter option
    input wire logic refClockOutPin, // pin data
    input wire logic refClockPinOe, // pin enable
    input wire logic refClockSlewLimit, // slew limit
    input wire logic modulatorClock // modulator clock
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    logic done; // completed transfer
    logic ctlWr; // completed control write outside sleep
    assign done = psel && penable && pready;
    assign ctlWr = done && pwrite && paddr == '0 && !sleep;
    a_ready_prompt: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    a_unmapped_err: assert property (done |-> pslverr == (paddr != 'h0 && paddr != 'h4))
        else $error("error flag wrong for address");
    a_err_rdata: assert property (done && pslverr && !pwrite |-> prdata == '0)
        else $error("refused read returned data");
    a_slew_follow: assert property (ctlWr |-> ##2 refClockSlewLimit == $past(pwdata[5], 2))
        else $error("slew limit not following control");
    a_crystal_no_drive: assert property ((crystalModeSel && !sleep) [*6] |=> !refClockPinOe)
        else $error("pin driven in crystal mode");
    // once ownership has settled, the pin must carry exactly the modulator clock
    a_pin_is_ref: assert property ((!crystalModeSel && !foscQuarterOutputEnable && !sleep) [*6]
        ##0 refClockPinOe |-> refClockOutPin == modulatorClock)
        else $error("pin differs from reference clock");
    a_sleep_freeze: assert property (sleep && $past(sleep)
        |-> $stable(modulatorClock) && $stable(refClockPinOe))
        else $error("outputs moved during sleep");
    a_reset_idle: assert property ($fell(rst)
        |-> !refClockPinOe && refClockSlewLimit && !modulatorClock && !pready)
        else $error("outputs not idle after reset");
    c_ctl_write: cover property (ctlWr);
    c_unmapped: cover property (done && pslverr);
    c_sleep_drive: cover property (sleep && refClockPinOe);
endmodule
bind rcd_ref_clock rcd_ref_clock_asserts #(.ADDR_W(ADDR_W)) rcd_ref_clock_asserts_inst (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sleep(sleep), .crystalModeSel(crystalModeSel),
    .foscQuarterOutputEnable(foscQuarterOutputEnable), .refClockOutPin(refClockOutPin),
    .refClockPinOe(refClockPinOe), .refClockSlewLimit(refClockSlewLimit),
    .modulatorClock(modulatorClock));

// *** rcd_far_side.sv ***
`timescale 1ns/1ps
module rcd_far_side (
    input wire logic clk, // system clock
    input wire logic rst, // reset
    input wire logic modClk, // clock fed to the modulator
    input wire logic pinOut, // shared pin data
    input wire logic pinOe, // shared pin enable
    output logic pad, // resolved pad level
    output logic [15:0] period, // cycles between rises
    output logic [15:0] highTime, // cycles high in last pulse
    output logic [15:0] rises // rising edges seen
);
    logic last; // previous sample
    logic [15:0] cyc, hc; // running counts
    // pull-up on the pad, so a released pin never shows its last value
    assign pad = pinOe ? pinOut : 1'b1;
    // modulator side measures the clock it is fed, mid-cycle where it is settled
    always @(negedge clk) begin
        if (rst) begin
            {last, cyc, hc, period, highTime, rises} <= '0;
        end else begin
            last <= modClk;
            cyc <= (modClk && !last) ? 16'h1 : cyc + 16'h1;
            hc <= (modClk && !last) ? 16'h1 : hc + {15'h0, modClk};
            if (modClk && !last) begin
                period <= cyc;
                rises <= rises + 16'h1;
            end
            if (!modClk && last) highTime <= hc;
        end
    end
endmodule

// *** rcd_ref_clock_bench.sv ***
`timescale 1ns/1ps
`include "rcd_defines.svh"
module rcd_ref_clock_bench;
    import rcd_pkg::*;
    logic clk = 1'b0; // 40 MHz
    logic rst = 1'b1; // held two cycles
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0; // apb controls
    logic [11:0] paddr = '0; // apb address
    logic [31:0] pwdata = '0, prdata, rd; // apb data, last read
    logic pready, pslverr, er; // apb answer, last error
    logic sleep = 1'b0, xtal = 1'b0, quarter = 1'b0; // device state
    logic pin, oe, slew, modClk, pad; // pin side
    logic [15:0] period, highTime, rises; // far side figures
    int err_total = 0, cmp_count = 0, cycles = 0; // tallies
    always #12.5 clk = ~clk;
    rcd_ref_clock rcd_ref_clock_inst (
        .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sleep(sleep), .crystalModeSel(xtal),
        .foscQuarterOutputEnable(quarter), .refClockOutPin(pin), .refClockPinOe(oe),
        .refClockSlewLimit(slew), .modulatorClock(modClk));
    rcd_far_side rcd_far_side_inst (
        .clk(clk), .rst(rst), .modClk(modClk), .pinOut(pin), .pinOe(oe),
        .pad(pad), .period(period), .highTime(highTime), .rises(rises));
    task automatic results;
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // a hang ends the run as a mismatch
    always @(posedge clk) begin
        cycles++;
        if (cycles == 30000) begin
            err_total++;
            results();
        end
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    // request held until ready is seen at an edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        logic got; // pready as the next edge will see it
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // look mid-cycle, where the answer stands, then let the sampling edge pass
        do begin
            @(negedge clk);
            got = pready;
            rd = prdata;
            er = pslverr;
            @(posedge clk);
        end while (got !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [31:0] d);
        apb(1'b1, `RCD_ADDR_CTRL, d);
    endtask
    task automatic tk(input int n);
        repeat (n) @(posedge clk);
    endtask
    function automatic logic [31:0] cfg(input logic en, oe, sl, input logic [1:0] du,
        input logic [2:0] dv);
        return {24'h0, en, oe, sl, du, dv};
    endfunction
    // two samples per cycle, mid-high and mid-low of clk
    task automatic samp(input int n, input bit usePad, output int h);
        h = 0;
        repeat (n) begin
            @(posedge clk);
            #6 h += ((usePad ? pad : modClk) === 1'b1);
            #12 h += ((usePad ? pad : modClk) === 1'b1);
        end
    endtask
    task automatic tResetState;
        apb(1'b0, `RCD_ADDR_CTRL, '0);
        chk("ctrl reset", `RCD_CTRL_RESET, rd);
        chk("oe reset", '0, oe);
        chk("slew reset", 32'h1, slew);
        chk("clock idle", '0, modClk);
    endtask
    task automatic tBus;
        apb(1'b1, `RCD_ADDR_CTRL, 32'hffff_ff00 | cfg(0, 0, 1, 2'd1, 3'd5));
        apb(1'b0, `RCD_ADDR_CTRL, '0);
        chk("ctrl readback", cfg(0, 0, 1, 2'd1, 3'd5), rd);
        apb(1'b1, 12'h008, 32'hff);
        chk("unmapped write err", 32'h1, er);
        apb(1'b0, 12'h008, '0);
        chk("unmapped read err", 32'h1, er);
        chk("unmapped data", '0, rd);
    endtask
    task automatic tDivide;
        logic [15:0] r0;
        wr(cfg(0, 0, 1, 2'd2, 3'd2));
        r0 = rises;
        tk(20);
        chk("disabled rises", r0, rises);
        for (int n = 2; n < 8; n++) begin
            wr(cfg(1, 0, 1, 2'd2, n[2:0]));
            tk(3 * (1 << n) + 4);
            chk("period", 1 << n, period);
            chk("high time", 1 << (n - 1), highTime);
        end
        for (int d = 1; d < 4; d++) begin
            wr(cfg(1, 0, 1, d[1:0], 3'd3));
            tk(28);
            chk("duty high", d * 2, highTime);
        end
        wr(cfg(1, 0, 1, 2'd0, 3'd3));
        tk(10);
        r0 = rises;
        tk(24);
        chk("zero duty rises", r0, rises);
    endtask
    task automatic tFast;
        int h;
        for (int n = 0; n < 2; n++) begin
            for (int d = 0; d < 4; d++) begin
                wr(cfg(1, 0, 1, d[1:0], n[2:0]));
                tk(4);
                samp(2, 0, h);
                chk("fast highs", (n == 0) ? ((d != 0) ? 2 : 0) : d, h);
            end
        end
    endtask
    task automatic tPin;
        int h;
        logic [15:0] r0;
        wr(cfg(1, 1, 1, 2'd2, 3'd2));
        tk(6);
        @(negedge clk);
        chk("oe on", 32'h1, oe);
        samp(8, 1, h);
        chk("pad highs", 32'd8, h);
        apb(1'b0, `RCD_ADDR_STAT, '0);
        chk("owner ref", RCD_PIN_REF, rd[1:0]);
        wr(cfg(1, 1, 1, 2'd1, 3'd3));
        xtal <= 1'b1;
        tk(8);
        @(negedge clk);
        chk("oe crystal", '0, oe);
        apb(1'b0, `RCD_ADDR_STAT, '0);
        chk("owner osc", RCD_PIN_OSC, rd[1:0]);
        r0 = rises;
        tk(16);
        chk("ref internal", 32'h1, rises != r0);
        xtal <= 1'b0;
        quarter <= 1'b1;
        tk(8);
        samp(8, 1, h);
        chk("quarter highs", 32'd8, h);
        apb(1'b0, `RCD_ADDR_STAT, '0);
        chk("owner quarter", RCD_PIN_QUARTER, rd[1:0]);
        quarter <= 1'b0;
        tk(8);
        wr(cfg(1, 0, 1, 2'd1, 3'd3));
        tk(4);
        @(negedge clk);
        chk("oe off", '0, oe);
    endtask
    task automatic tSlew;
        wr(cfg(0, 0, 0, 2'd2, 3'd0));
        tk(3);
        @(negedge clk);
        chk("slew off", '0, slew);
        wr(cfg(0, 0, 1, 2'd2, 3'd0));
        tk(3);
        @(negedge clk);
        chk("slew on", 32'h1, slew);
    endtask
    task automatic tSleep;
        int h;
        logic held;
        logic [15:0] r0;
        wr(cfg(1, 1, 1, 2'd2, 3'd3));
        tk(10);
        sleep <= 1'b1;
        #1 held = modClk;
        r0 = rises;
        samp(20, 0, h);
        chk("sleep level", held ? 40 : 0, h);
        chk("sleep rises", r0, rises);
        @(posedge clk);
        sleep <= 1'b0;
        tk(20);
        chk("wake rises", 32'h1, rises != r0);
    endtask
    task automatic tMidReset;
        wr(cfg(1, 1, 0, 2'd2, 3'd2));
        tk(5);
        rst <= 1'b1;
        tk(2);
        rst <= 1'b0;
        #1 chk("oe after reset", '0, oe);
        chk("clock after reset", '0, modClk);
        apb(1'b0, `RCD_ADDR_CTRL, '0);
        chk("ctrl after reset", `RCD_CTRL_RESET, rd);
        wr(cfg(0, 0, 1, 2'd2, 3'd2));
        wr(cfg(1, 0, 1, 2'd2, 3'd2));
        tk(16);
        chk("period after init", 32'd4, period);
    endtask
    initial begin
        tk(2);
        rst <= 1'b0;
        tResetState();
        tBus();
        tDivide();
        tFast();
        tPin();
        tSlew();
        tSleep();
        tMidReset();
        results();
    end
endmodule
